// *** design/pch_map.svh ***
// Register offsets, field positions and reset values of the header block
`ifndef PCH_MAP_SVH
`define PCH_MAP_SVH
`define PCH_OFF_ID        12'h000
`define PCH_OFF_CMDSTAT   12'h004
`define PCH_OFF_CLASS     12'h008
`define PCH_OFF_WIN0      12'h010
`define PCH_OFF_WIN5      12'h024
`define PCH_OFF_CARDINFO  12'h028
`define PCH_OFF_ROM       12'h030
`define PCH_OFF_CAPPTR    12'h034
`define PCH_WIN_SETTING   32'hFF000000
`define PCH_WIN_FIXED     32'hFF000000
`define PCH_ROM_SETTING   32'hFF000000
`define PCH_ROM_FIXED     32'hFF000000
`define PCH_CAPABILITY_CHAIN_POINTER_RST   8'h40
`define PCH_CARD_PTR_RST  32'h00000000
`define PCH_CLASS_RST     24'hFF0000
// Arbitrary part identifier default, names no real part
`define PCH_PART_ID_RST   16'hBEEF
`define PCH_MAKER_ID_RST  16'h1234
`define PCH_REV_RST       8'h00
`define PCH_ZERO32        32'h00000000
`define PCH_WIN_TYPE_MSK  32'h0000000F
`define PCH_ROM_DEC_MSK   32'hFFFFF800
`define PCH_ROM_EN_BIT    0
`define PCH_STAT_CAP_BIT  20
`define PCH_CMD_IO_BIT    0
`define PCH_CMD_MEM_BIT   1
`define PCH_CMD_WR_MSK    32'h00000003
`define PCH_WIN_IO_BIT    0
`define PCH_WIN_COUNT     6
`endif

// *** design/pch_pkg.sv ***
// Types shared by the configuration header block
package pch_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } pch_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pch_apb_rsp_s;
  typedef enum logic [1:0] {
    PCH_IDLE = 2'b01,
    PCH_ACK  = 2'b10
  } pch_phase_e;
  typedef logic [31:0] pch_word_t;
endpackage

// *** design/pch_config_header.sv ***
// Parameter-shaped PCI configuration header reached over APB
//
// Functional notes
// R1: Six window settings, indexed 0-5, default FF000000, give type and decoded bits.
// R2: Per-window fixed enable, default off, selects a fixed address from power-up.
// R3: Fixed 32-bit address sets the stored base when enabled, else ignored.
// R4: Reading a window with fixed enable returns the fixed address.
// R5: Fixed windows hit by comparing the bus address with decoded fixed bits.
// R6: Capability enable sets status bit4 and loads the capability pointer.
// R7: Capability pointer defaults to 40 and is ignored when the chain is off.
// R8: Card info pointer disabled reads as all zeros.
// R9: Card info pointer enabled reads the configured value, default zero.
// R10: 24-bit class code, default FF0000, is returned on reads.
// R11: 16-bit part identifier value is returned in the identification register.
// R12: Enabled expansion ROM takes size and decoded bits from its setting.
// R13: Disabled expansion ROM register is read-only and reads zero.
// R14: Expansion ROM decodes only address bits 31 to 11, else like windows.
// R15: Writes to parameter-fixed fields leave them unchanged.
`timescale 1ns/1ps
`include "pch_map.svh"

module pch_config_header #(
  parameter logic [191:0] window_setting          = {6{`PCH_WIN_SETTING}},
  parameter logic [5:0]   window_fixed_enable     = 6'h00,
  parameter logic [191:0] window_fixed_address    = {6{`PCH_WIN_FIXED}},
  parameter logic         capability_chain_enable = 1'b0,
  parameter logic [7:0]   capability_chain_pointer = `PCH_CAPABILITY_CHAIN_POINTER_RST,
  parameter logic         card_info_pointer_enable = 1'b0,
  parameter logic [31:0]  card_info_pointer       = `PCH_CARD_PTR_RST,
  parameter logic [23:0]  class_code_value        = `PCH_CLASS_RST,
  parameter logic [15:0]  part_identifier_value   = `PCH_PART_ID_RST,
  // Arbitrary maker code, not tied to any vendor
  parameter logic [15:0]  maker_identifier_value  = `PCH_MAKER_ID_RST,
  parameter logic         rom_enable              = 1'b0,
  parameter logic [31:0]  rom_setting             = `PCH_ROM_SETTING,
  parameter logic         rom_fixed_enable        = 1'b0,
  parameter logic [31:0]  rom_fixed_address       = `PCH_ROM_FIXED
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 bus_addr_valid,
  input  wire logic [31:0]          bus_addr,
  output logic [5:0]                window_hit,
  output logic                      rom_hit,
  output logic                      io_space_enable,
  output logic                      mem_space_enable
);
  import pch_pkg::*;

  // ==========================================================
  // Helpers
  function automatic pch_word_t dec_mask(input pch_word_t setting);
    dec_mask = setting & ~`PCH_WIN_TYPE_MSK; // see R1
  endfunction

  function automatic logic addr_match(input pch_word_t addr, input pch_word_t base,
                                      input pch_word_t mask);
    addr_match = ((addr ^ base) & mask) == `PCH_ZERO32;
  endfunction

  // ==========================================================
  // State
  pch_phase_e   phase;
  pch_phase_e   next_phase;
  pch_apb_req_s req;
  pch_apb_rsp_s rsp;
  pch_apb_rsp_s next_rsp;
  pch_word_t    win_base [`PCH_WIN_COUNT];
  pch_word_t    next_win_base [`PCH_WIN_COUNT];
  pch_word_t    rom_base;
  pch_word_t    next_rom_base;
  logic [1:0]   cmd;
  logic [1:0]   next_cmd;
  logic [5:0]   next_window_hit;
  logic         next_rom_hit;
  logic         access_done;
  logic         mapped;
  pch_word_t    rd_word;
  pch_word_t    rom_mask;

  assign req.paddr  = paddr;
  assign req.pwrite = pwrite;
  assign req.pwdata = pwdata;
  assign rom_mask   = rom_setting & `PCH_ROM_DEC_MSK; // see R14

  // Write lands only on the edge where the master sees pready
  assign access_done = psel & penable & rsp.pready;

  // ==========================================================
  // Read decode
  always_comb begin
    rd_word = `PCH_ZERO32;
    mapped  = 1'b1;
    if (req.paddr == `PCH_OFF_ID) begin
      rd_word = {part_identifier_value, maker_identifier_value}; // see R11
    end else if (req.paddr == `PCH_OFF_CMDSTAT) begin
      rd_word = {30'h0, cmd};
      rd_word[`PCH_STAT_CAP_BIT] = capability_chain_enable; // see R6
    end else if (req.paddr == `PCH_OFF_CLASS) begin
      rd_word = {class_code_value, `PCH_REV_RST}; // see R10
    end else if (req.paddr >= `PCH_OFF_WIN0 && req.paddr <= `PCH_OFF_WIN5 &&
                 req.paddr[1:0] == 2'h0) begin
      rd_word = win_base[3'(req.paddr[4:2] - 3'h4)];
    end else if (req.paddr == `PCH_OFF_CARDINFO) begin
      // Disabled pointer reads zero
      rd_word = card_info_pointer_enable ? card_info_pointer : `PCH_ZERO32; // see R8 R9
    end else if (req.paddr == `PCH_OFF_ROM) begin
      rd_word = rom_enable ? rom_base : `PCH_ZERO32; // see R13
    end else if (req.paddr == `PCH_OFF_CAPPTR) begin
      // Pointer hidden while the chain is off
      rd_word = capability_chain_enable ? {24'h0, capability_chain_pointer} // see R7
                                        : `PCH_ZERO32;
    end else if (req.paddr[11:8] == 4'h0) begin
      rd_word = `PCH_ZERO32;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================
  // APB phase machine
  always_comb begin
    next_phase = phase;
    next_rsp   = rsp;
    case (phase)
      PCH_IDLE: begin
        next_rsp.pready = 1'b0;
        if (psel && !penable) begin
          next_phase       = PCH_ACK;
          next_rsp.pready  = 1'b1;
          next_rsp.pslverr = ~mapped;
          next_rsp.prdata  = (req.pwrite || !mapped) ? `PCH_ZERO32 : rd_word;
        end
      end
      PCH_ACK: begin
        next_phase       = PCH_IDLE;
        next_rsp.pready  = 1'b0;
        next_rsp.pslverr = 1'b0;
        next_rsp.prdata  = `PCH_ZERO32;
      end
      default: begin
        next_phase = PCH_IDLE;
        next_rsp   = '0;
      end
    endcase
  end

  // ==========================================================
  // Stored bases and command bits
  always_comb begin
    next_cmd      = cmd;
    next_rom_base = rom_base;
    for (int i = 0; i < `PCH_WIN_COUNT; i++) begin
      next_win_base[i] = win_base[i];
    end
    if (access_done && req.pwrite) begin
      if (req.paddr == `PCH_OFF_CMDSTAT) begin
        next_cmd = req.pwdata[1:0] & 2'(`PCH_CMD_WR_MSK);
      end
      for (int i = 0; i < `PCH_WIN_COUNT; i++) begin
        // Fixed windows ignore writes
        if (!window_fixed_enable[i] &&
            req.paddr == 12'(`PCH_OFF_WIN0 + 4 * i)) begin // see R15
          next_win_base[i] = (req.pwdata & dec_mask(window_setting[32*i +: 32])) |
                             (window_setting[32*i +: 32] & `PCH_WIN_TYPE_MSK); // see R1
        end
      end
      if (req.paddr == `PCH_OFF_ROM && rom_enable && !rom_fixed_enable) begin // see R13 R15
        next_rom_base = (req.pwdata & rom_mask) | // see R12
                        (req.pwdata & 32'(1 << `PCH_ROM_EN_BIT));
      end
    end
  end

  // ==========================================================
  // Address hit
  always_comb begin
    for (int i = 0; i < `PCH_WIN_COUNT; i++) begin
      next_window_hit[i] = bus_addr_valid &&
        (win_base[i][`PCH_WIN_IO_BIT] ? cmd[`PCH_CMD_IO_BIT] : cmd[`PCH_CMD_MEM_BIT]) &&
        addr_match(bus_addr, win_base[i], dec_mask(window_setting[32*i +: 32])); // see R5
    end
    // Disabled decoder never hits
    next_rom_hit = bus_addr_valid && rom_enable && cmd[`PCH_CMD_MEM_BIT] &&
                   rom_base[`PCH_ROM_EN_BIT] &&
                   addr_match(bus_addr, rom_base, rom_mask); // see R12 R14
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase    <= PCH_IDLE;
      rsp      <= '0;
      cmd      <= 2'h0;
      for (int i = 0; i < `PCH_WIN_COUNT; i++) begin
        // Fixed address from power-up, else only the type bits
        win_base[i] <= window_fixed_enable[i] ? window_fixed_address[32*i +: 32] // see R2 R3 R4
                                              : window_setting[32*i +: 32] & `PCH_WIN_TYPE_MSK;
      end
      rom_base   <= rom_fixed_enable ? rom_fixed_address : `PCH_ZERO32;
      window_hit <= 6'h00;
      rom_hit    <= 1'b0;
    end else begin
      phase      <= next_phase;
      rsp        <= next_rsp;
      cmd        <= next_cmd;
      win_base   <= next_win_base;
      rom_base   <= next_rom_base;
      window_hit <= next_window_hit;
      rom_hit    <= next_rom_hit;
    end
  end

  assign prdata           = rsp.prdata;
  assign pready           = rsp.pready;
  assign pslverr          = rsp.pslverr;
  assign io_space_enable  = cmd[`PCH_CMD_IO_BIT];
  assign mem_space_enable = cmd[`PCH_CMD_MEM_BIT];

endmodule // pch_config_header

// *** testbench/pch_config_header_sva.sv ***
// Port-level checks of the configuration header block
`timescale 1ns/1ps
module pch_config_header_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bus_addr_valid,
  input wire logic [31:0] bus_addr,
  input wire logic [5:0]  window_hit,
  input wire logic        rom_hit,
  input wire logic        io_space_enable,
  input wire logic        mem_space_enable
);
  // ==========
  // Bus and hit relations
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer held too long");
  property p_unmap; psel && !penable && paddr[11:8] != 4'h0 |=> pslverr && prdata == 0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_mapped; psel && !penable && paddr[11:8] == 4'h0 |=> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_idle; !pready |-> prdata == 0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("answer lines busy when idle");
  property p_hcause; !bus_addr_valid |=> window_hit == 0 && !rom_hit; endproperty
  a_hcause: assert property (p_hcause) else $error("hit without address");
  property p_hmem; !mem_space_enable && !io_space_enable |=> window_hit == 0 && !rom_hit;
  endproperty
  a_hmem: assert property (p_hmem) else $error("hit with decoding off");
  property p_cmd; psel && penable && pready && pwrite && paddr == 12'h004 |=>
    mem_space_enable == $past(pwdata[1]) && io_space_enable == $past(pwdata[0]); endproperty
  a_cmd: assert property (p_cmd) else $error("command bits not written");
endmodule // pch_config_header_sva

// *** testbench/pch_apb_host.sv ***
// APB host model issuing configuration reads and writes
`timescale 1ns/1ps
module pch_apb_host (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // Request held until pready seen; bounded so a dead slave cannot hang the run
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic tmo);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    tmo = (n >= 16);
    penable <= 1'b0;
  endtask
  task automatic idle();
    psel <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule // pch_apb_host

// *** testbench/pch_config_header_tb.sv ***
// Self-checking bench for the configuration header block
`timescale 1ns/1ps
`include "pch_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module pch_config_header_tb;
  import pch_pkg::*;
  localparam pch_word_t   FIX0 = 32'hA5000000;
  localparam pch_word_t   CARD = 32'h00001234;
  localparam logic [15:0] PID  = 16'h5A3C; // Arbitrary identifier
  logic        ref_clk, rst, psel, penable, pwrite, bva, pready, pslverr, rom_hit, io_en, mem_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, bus_addr, rd, st;
  logic [5:0]  hit;
  logic        err, tmo;
  int          mismatches, checked;
  pch_word_t   mdl [int];
  logic [11:0] addrs [14] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018,
                              12'h01C, 12'h020, 12'h024, 12'h028, 12'h030, 12'h034, 12'h200};
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  pch_config_header #(.window_fixed_enable(6'h01), .window_fixed_address({{5{`PCH_WIN_FIXED}}, FIX0}),
    .capability_chain_enable(1'b1), .capability_chain_pointer(8'h48),
    .card_info_pointer_enable(1'b1), .card_info_pointer(CARD), .part_identifier_value(PID)) dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_addr_valid(bva),
    .bus_addr(bus_addr), .window_hit(hit), .rom_hit(rom_hit), .io_space_enable(io_en),
    .mem_space_enable(mem_en));
  pch_apb_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic pch_word_t xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========
  // Bus access against the model; only unfixed windows and command bits take writes
  task automatic io(input logic wr, input logic [11:0] a, input pch_word_t d);
    host.xfer(wr, a, d, rd, err, tmo);
    `CHK(tmo, 1'b0)
    if (tmo) conclude();
    `CHK(err, a[11:8] != 4'h0)
    if (!wr) `CHK(rd, mdl[a])
    if (wr && a >= 12'h014 && a <= 12'h024) mdl[a] = d & 32'hFF000000;
    if (wr && a == 12'h004) mdl[a] = 32'h00100000 | (d & 32'h00000003);
  endtask
  task automatic probe(input int w);
    pch_word_t b;
    logic [5:0] eh;
    b = (mdl[16 + 4 * w] & 32'hFF000000) | (xs() & 32'h00FFFFFF);
    for (int i = 0; i < 6; i++) eh[i] = mdl[4][1] && (((b ^ mdl[16 + 4 * i]) & 32'hFF000000) == 0);
    bva <= 1'b1;
    bus_addr <= b;
    @(posedge ref_clk);
    bva <= 1'b0;
    @(posedge ref_clk);
    `CHK(hit, eh)
    `CHK(rom_hit, 1'b0)
  endtask
  initial begin
    rst = 1'b1;
    bva = 1'b0;
    bus_addr = 32'h00000000;
    st = 32'h06DEC6EC;
    foreach (addrs[j]) mdl[addrs[j]] = 32'h00000000;
    mdl[0] = {PID, `PCH_MAKER_ID_RST};
    mdl[4] = 32'h00100000;
    mdl[8] = {`PCH_CLASS_RST, 8'h00};
    mdl[16] = FIX0;
    mdl[40] = CARD;
    mdl[52] = 32'h00000048;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (addrs[j]) begin
      io(1'b0, addrs[j], 32'h00000000);
      io(1'b1, addrs[j], xs());
      io(1'b0, addrs[j], 32'h00000000);
    end
    io(1'b1, 12'h004, 32'h00000000);
    host.idle();
    probe(0);
    probe(1);
    io(1'b1, 12'h004, 32'h00000002);
    host.idle();
    `CHK(mem_en, 1'b1)
    `CHK(io_en, 1'b0)
    for (int j = 0; j < 12; j++) probe(j % 6);
    conclude();
  end
endmodule // pch_config_header_tb
bind pch_config_header pch_config_header_sva chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bus_addr_valid(bus_addr_valid), .bus_addr(bus_addr),
  .window_hit(window_hit), .rom_hit(rom_hit), .io_space_enable(io_space_enable),
  .mem_space_enable(mem_space_enable));
